// ==== hdl/bmu_core.sv ====
// Function
// - bit compare: Z set when bits equal
// - compare keeps operands, C/D/H; clears S
// - complement inverts only the selected bit
// - complement: Z from result, S cleared
// - 77h direction 0 clears bit, no flags
// - 77h direction 1 sets bit, no flags
// - bit OR into destination bit zero
// - bit OR source bit zero into bit b
// - branch when tested bit is zero
// - displacement is a signed byte
// - second byte: register, bit, direction
// - flags live at register index d5h
`timescale 1ns/1ps
module bmu_core
  import bmu_pkg::*;
#(
  parameter logic [7:0] WRK_BASE = WRK_BASE_DEF
) (
  input  wire logic   aclk,    // core clock, 250 MHz
  input  wire logic   aresetn, // synchronous reset, active low
  input  bmu_axi_req_t axi_req, // axi4-lite master side
  output bmu_axi_rsp_t axi_rsp  // axi4-lite slave side
);

  bmu_state_t q;
  bmu_state_t d;
  logic [7:0] mem [256];

  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic       flags_we;
  logic [7:0] flags_wd;

  logic [7:0] wreg_idx;
  logic [7:0] dst_addr;
  logic [7:0] src_addr;
  logic [7:0] dst_cur;
  logic [7:0] src_cur;
  logic [7:0] flags_cur;
  logic [7:0] bmask;
  logic [7:0] res;
  logic       src_bit;
  logic       commit;

  function automatic bmu_op_t decode(input bmu_instr_t i);
    case (i.opcode)
      OPC_BIT_COMPARE:         decode = i.dir ? OP_BAD : OP_CMP;
      OPC_BIT_COMPLEMENT:      decode = i.dir ? OP_BAD : OP_COMP;
      OPC_BIT_CLR_SET:         decode = i.dir ? OP_SET : OP_CLR;
      OPC_BIT_OR:              decode = i.dir ? OP_OR_TOB : OP_OR_TO0;
      OPC_BRANCH_IF_BIT_CLEAR: decode = i.dir ? OP_BAD : OP_BRCLR;
      default:                 decode = OP_BAD;
    endcase
  endfunction : decode

  function automatic logic [3:0] cycles(input bmu_op_t op);
    case (op)
      OP_CMP:               cycles = CYC_BIT_COMPARE;
      OP_OR_TO0, OP_OR_TOB: cycles = CYC_BIT_OR;
      OP_BRCLR:             cycles = CYC_BRANCH;
      default:              cycles = CYC_SHORT;
    endcase
  endfunction : cycles

  function automatic logic [7:0] zs_flags(input logic [7:0] f, input logic z);
    logic [7:0] r;
    r         = f;
    r[FLAG_Z] = z;
    r[FLAG_S] = 1'b0;
    return r;
  endfunction : zs_flags

  function automatic logic [7:0] merge_byte(input logic [7:0] o, input logic [7:0] n, input logic s);
    merge_byte = s ? n : o;
  endfunction : merge_byte

  // operand fetch from the register file
  assign wreg_idx  = 8'(WRK_BASE + {4'h0, q.instr.wreg});
  assign dst_addr  = (q.op == OP_OR_TOB) ? q.instr.arg : wreg_idx;
  assign src_addr  = (q.op == OP_OR_TOB) ? wreg_idx : q.instr.arg;
  assign dst_cur   = mem[dst_addr];
  assign src_cur   = mem[src_addr];
  assign flags_cur = mem[FLAGS_IDX];
  assign bmask     = 8'h01 << q.instr.bidx;
  assign src_bit   = src_cur[q.instr.bidx];
  assign commit    = q.busy && (q.cnt == 4'h0);
  assign axi_rsp   = q.rsp;

  always_comb begin
    d        = q;
    mem_we   = 1'b0;
    mem_wa   = dst_addr;
    mem_wd   = 8'h00;
    flags_we = 1'b0;
    flags_wd = flags_cur;
    res      = dst_cur;

    // write address and data, either order
    if (axi_req.awvalid && q.rsp.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      d.rsp.bvalid = 1'b0;
    end

    if (q.aw_got && q.w_got && !q.rsp.bvalid) begin
      d.aw_got     = 1'b0;
      d.w_got      = 1'b0;
      d.rsp.bvalid = 1'b1;
      d.rsp.bresp  = RESP_OKAY;
      if (q.awaddr[ADDR_W-1:ADDR_W-2] == AREA_REGFILE) begin
        if (q.busy) begin
          d.rsp.bresp = RESP_SLVERR;
        end else begin
          mem_we = q.wstrb[0];
          mem_wa = q.awaddr[9:2];
          mem_wd = q.wdata[7:0];
        end
      end else begin
        case ({q.awaddr[ADDR_W-1:2], 2'b00})
          ADDR_PC: begin
            if (q.busy) begin
              d.rsp.bresp = RESP_SLVERR;
            end else begin
              d.pc[7:0]  = merge_byte(q.pc[7:0], q.wdata[7:0], q.wstrb[0]);
              d.pc[15:8] = merge_byte(q.pc[15:8], q.wdata[15:8], q.wstrb[1]);
            end
          end
          ADDR_INSTR: begin
            if (q.busy) begin
              d.rsp.bresp = RESP_SLVERR;
            end else begin
              d.instr[7:0]   = merge_byte(q.instr[7:0], q.wdata[7:0], q.wstrb[0]);
              d.instr[15:8]  = merge_byte(q.instr[15:8], q.wdata[15:8], q.wstrb[1]);
              d.instr[23:16] = merge_byte(q.instr[23:16], q.wdata[23:16], q.wstrb[2]);
              if (q.wstrb[0]) begin
                d.op      = decode(d.instr);
                d.done    = 1'b0;
                d.taken   = 1'b0;
                d.illegal = (d.op == OP_BAD);
                d.busy    = (d.op != OP_BAD);
                d.cnt     = 4'(cycles(d.op) - 4'h1);
              end
            end
          end
          ADDR_STATUS: begin
          end
          default: begin
            d.rsp.bresp = RESP_SLVERR;
          end
        endcase
      end
    end

    // execution: hold for the instruction's cycle count, then commit
    if (q.busy) begin
      if (q.cnt != 4'h0) begin
        d.cnt = 4'(q.cnt - 4'h1);
      end else begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.pc   = 16'(q.pc + LEN_LONG);
        case (q.op)
          OP_CMP: begin
            flags_we = 1'b1;
            flags_wd = zs_flags(flags_cur, dst_cur[0] == src_bit);
          end
          OP_COMP: begin
            res      = dst_cur ^ bmask;
            mem_we   = 1'b1;
            flags_we = 1'b1;
            flags_wd = zs_flags(flags_cur, res == 8'h00);
            d.pc     = 16'(q.pc + LEN_SHORT);
          end
          OP_CLR: begin
            res    = dst_cur & ~bmask;
            mem_we = 1'b1;
            d.pc   = 16'(q.pc + LEN_SHORT);
          end
          OP_SET: begin
            res    = dst_cur | bmask;
            mem_we = 1'b1;
            d.pc   = 16'(q.pc + LEN_SHORT);
          end
          OP_OR_TO0: begin
            res      = {dst_cur[7:1], dst_cur[0] | src_bit};
            mem_we   = 1'b1;
            flags_we = 1'b1;
            flags_wd = zs_flags(flags_cur, !res[0]);
          end
          OP_OR_TOB: begin
            res      = dst_cur | (src_cur[0] ? bmask : 8'h00);
            mem_we   = 1'b1;
            flags_we = 1'b1;
            flags_wd = zs_flags(flags_cur, !res[q.instr.bidx]);
          end
          OP_BRCLR: begin
            if (!dst_cur[q.instr.bidx]) begin
              d.taken = 1'b1;
              d.pc    = 16'(q.pc + LEN_LONG + {{8{q.instr.arg[7]}}, q.instr.arg});
            end
          end
          default: begin
          end
        endcase
        mem_wa = dst_addr;
        mem_wd = res;
      end
    end

    // read channel
    if (q.rsp.rvalid && axi_req.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && q.rsp.arready) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp  = RESP_OKAY;
      d.rsp.rdata  = 32'h0000_0000;
      if (axi_req.araddr[ADDR_W-1:ADDR_W-2] == AREA_REGFILE) begin
        d.rsp.rdata = {24'h00_0000, mem[axi_req.araddr[9:2]]};
      end else begin
        case ({axi_req.araddr[ADDR_W-1:2], 2'b00})
          ADDR_PC:     d.rsp.rdata = {16'h0000, q.pc};
          ADDR_INSTR:  d.rsp.rdata = {8'h00, q.instr};
          ADDR_STATUS: d.rsp.rdata = {28'h000_0000, q.taken, q.illegal, q.done, q.busy};
          default:     d.rsp.rresp = RESP_SLVERR;
        endcase
      end
    end

    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_got && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.op    <= OP_NONE;
    end else begin
      q <= d;
    end
  end

  // register file; flags port last so the flag update wins on a clash
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (flags_we) begin
      mem[FLAGS_IDX] <= flags_wd;
    end
  end

  sequence busy6_s;
    q.busy [*6] ##1 !q.busy;
  endsequence

  sequence busy4_s;
    q.busy [*4] ##1 !q.busy;
  endsequence

  cmp_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.busy) && q.op == OP_CMP |-> busy6_s)
    else $error("bit compare did not take six cycles");

  cmp_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_CMP |=> !flags_cur[FLAG_S]
      && ((flags_cur & FLAG_KEEP_MASK) == ($past(flags_cur) & FLAG_KEEP_MASK))
      && flags_cur[FLAG_Z] == ($past(dst_cur[0]) == $past(src_bit)) && $stable(dst_cur))
    else $error("bit compare flags or operands wrong");

  comp_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.busy) && q.op == OP_COMP |-> busy4_s ##0 (dst_cur == ($past(dst_cur, 4) ^ bmask)))
    else $error("bit complement result wrong");

  comp_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_COMP |=> flags_cur[FLAG_Z] == (dst_cur == 8'h00) && !flags_cur[FLAG_S]
      && flags_cur[FLAG_C] == $past(flags_cur[FLAG_C]))
    else $error("bit complement flags wrong");

  clr_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_CLR |=> dst_cur == ($past(dst_cur) & ~bmask) && $stable(flags_cur))
    else $error("bit clear wrong");

  set_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_SET |=> dst_cur == ($past(dst_cur) | bmask) && $stable(flags_cur))
    else $error("bit set wrong");

  or_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_OR_TO0 |=> dst_cur[0] == ($past(dst_cur[0]) | $past(src_bit))
      && dst_cur[7:1] == $past(dst_cur[7:1]) && flags_cur[FLAG_Z] == !dst_cur[0])
    else $error("bit or into bit zero wrong");

  or_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_OR_TOB |=> dst_cur == ($past(dst_cur) | ($past(src_cur[0]) ? bmask : 8'h00))
      && $stable(src_cur))
    else $error("bit or into bit b wrong");

  branch_pc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_BRCLR |=> q.pc == ($past(dst_cur[q.instr.bidx])
      ? 16'($past(q.pc) + LEN_LONG)
      : 16'($past(q.pc) + LEN_LONG + 16'($signed(q.instr.arg)))) && $stable(flags_cur))
    else $error("branch target wrong");

  branch_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.busy) && q.op == OP_BRCLR |-> ##9 q.busy ##1 !q.busy)
    else $error("branch did not take ten cycles");

  short_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.busy) && (q.op == OP_CLR || q.op == OP_SET) |-> busy4_s)
    else $error("bit clear or set did not take four cycles");

  or_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(q.busy) && (q.op == OP_OR_TO0 || q.op == OP_OR_TOB) |-> busy6_s)
    else $error("bit or did not take six cycles");

  or_high_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_OR_TOB |=> flags_cur[FLAG_Z] == !dst_cur[q.instr.bidx] && !flags_cur[FLAG_S]
      && ((flags_cur & FLAG_KEEP_MASK) == ($past(flags_cur) & FLAG_KEEP_MASK)))
    else $error("bit or into bit b flags wrong");

  comp_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && q.op == OP_COMP |=> (flags_cur & FLAG_KEEP_MASK) == ($past(flags_cur) & FLAG_KEEP_MASK))
    else $error("bit complement disturbed kept flags");

  pc_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && (q.op == OP_COMP || q.op == OP_CLR || q.op == OP_SET)
      |=> q.pc == 16'($past(q.pc) + LEN_SHORT))
    else $error("two-byte instruction pc step wrong");

  pc_long_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && (q.op == OP_CMP || q.op == OP_OR_TO0 || q.op == OP_OR_TOB)
      |=> q.pc == 16'($past(q.pc) + LEN_LONG))
    else $error("three-byte instruction pc step wrong");

endmodule : bmu_core

// ==== hdl/bmu_pkg.sv ====
package bmu_pkg;

  // opcodes
  localparam logic [7:0] OPC_BIT_COMPARE         = 8'h17;
  localparam logic [7:0] OPC_BIT_COMPLEMENT      = 8'h57;
  localparam logic [7:0] OPC_BIT_CLR_SET         = 8'h77;
  localparam logic [7:0] OPC_BIT_OR              = 8'h07;
  localparam logic [7:0] OPC_BRANCH_IF_BIT_CLEAR = 8'h37;

  // execution lengths in core cycles
  localparam logic [3:0] CYC_BIT_COMPARE = 4'h6;
  localparam logic [3:0] CYC_SHORT       = 4'h4;
  localparam logic [3:0] CYC_BIT_OR      = 4'h6;
  localparam logic [3:0] CYC_BRANCH      = 4'ha;

  // instruction lengths in bytes
  localparam logic [15:0] LEN_SHORT = 16'h0002;
  localparam logic [15:0] LEN_LONG  = 16'h0003;

  // register file
  localparam logic [7:0] FLAGS_IDX    = 8'hd5;
  localparam logic [7:0] WRK_BASE_DEF = 8'hc0;

  // flag bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam logic [7:0] FLAG_KEEP_MASK = 8'h9c;

  // bus map: register file words at 4 * index, control words above
  localparam int             ADDR_W       = 12;
  localparam logic [1:0]     AREA_REGFILE = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_PC     = 12'h400;
  localparam logic [ADDR_W-1:0] ADDR_INSTR  = 12'h404;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h408;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE, OP_CMP, OP_COMP, OP_CLR, OP_SET, OP_OR_TO0, OP_OR_TOB, OP_BRCLR, OP_BAD
  } bmu_op_t;

  // second byte: register, bit index, direction in the lsb
  typedef struct packed {
    logic [7:0] arg;
    logic [3:0] wreg;
    logic [2:0] bidx;
    logic       dir;
    logic [7:0] opcode;
  } bmu_instr_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } bmu_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bmu_axi_rsp_t;

  typedef struct packed {
    bmu_axi_rsp_t      rsp;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [15:0]       pc;
    bmu_instr_t        instr;
    bmu_op_t           op;
    logic              busy;
    logic [3:0]        cnt;
    logic              done;
    logic              illegal;
    logic              taken;
  } bmu_state_t;

endpackage : bmu_pkg

// ==== tb/tb_bit_manipulation_unit.sv ====
`timescale 1ns/1ps
module tb_bit_manipulation_unit;
  import bmu_pkg::*;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  a0;
    logic [7:0]  s0;
    logic [7:0]  f0;
    logic [7:0]  a1;
    logic [7:0]  s1;
    logic [7:0]  f1;
    logic [15:0] pc1;
  } bmu_row_t;

  logic         aclk;
  logic         aresetn;
  bmu_axi_req_t req;
  bmu_axi_rsp_t rsp;
  int           err_total;
  int           check_count;
  int           cyc;
  int           el;
  int           n;
  logic [31:0]  rv;
  logic [1:0]   rr;
  logic [11:0]  ra;
  bmu_row_t     rows[14];

  bmu_core bmu_core_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (req),
    .axi_rsp (rsp)
  );

  always #2 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  task automatic test_done;
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int k;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && k < 60);
    req.bready <= 1'b0;
    cmp("bvalid", 32'h1, {31'h0, rsp.bvalid});
    cmp("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && k < 60);
    req.rready <= 1'b0;
    cmp("rvalid", 32'h1, {31'h0, rsp.rvalid});
    d  = rsp.rdata;
    rr = rsp.rresp;
  endtask : rd

  task automatic wait_idle(output logic [31:0] s);
    rd(ADDR_STATUS, s);
    for (int i = 0; i < 30 && s[0] !== 1'b0; i++) rd(ADDR_STATUS, s);
  endtask : wait_idle

  task automatic exec(input logic [23:0] ins, output int cycles);
    int          t0;
    logic [31:0] s;
    wr(ADDR_INSTR, {8'h00, ins}, 4'hf, RESP_OKAY);
    t0 = cyc;
    rd(ADDR_STATUS, s);
    cmp("busy", 32'h1, {31'h0, s[0]});
    wait_idle(s);
    cmp("done", 32'h2, s & 32'h3);
    cycles = cyc - t0;
  endtask : exec

  function automatic int ncyc(input logic [7:0] op);
    case (op)
      OPC_BIT_COMPARE:         return int'(CYC_BIT_COMPARE);
      OPC_BIT_OR:              return int'(CYC_BIT_OR);
      OPC_BRANCH_IF_BIT_CLEAR: return int'(CYC_BRANCH);
      default:                 return int'(CYC_SHORT);
    endcase
  endfunction : ncyc

  initial begin
    repeat (6000) @(posedge aclk);
    err_total++;
    test_done();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    req = '0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    // op, byte2, byte3, dst, src, flags in; dst, src, flags, pc out
    rows[0]  = '{8'h17, 8'h12, 8'h01, 8'h07, 8'h01, 8'hbc, 8'h07, 8'h01, 8'h9c, 16'h0103};
    rows[1]  = '{8'h17, 8'h10, 8'h01, 8'h07, 8'h01, 8'hbc, 8'h07, 8'h01, 8'hdc, 16'h0103};
    rows[2]  = '{8'h57, 8'h12, 8'h01, 8'h07, 8'h01, 8'hbc, 8'h05, 8'h01, 8'h9c, 16'h0102};
    rows[3]  = '{8'h57, 8'h1e, 8'h01, 8'h80, 8'h01, 8'h20, 8'h00, 8'h01, 8'h40, 16'h0102};
    rows[4]  = '{8'h57, 8'hf0, 8'h01, 8'hfe, 8'h01, 8'h00, 8'hff, 8'h01, 8'h00, 16'h0102};
    rows[5]  = '{8'h77, 8'h12, 8'h01, 8'h07, 8'h01, 8'hbc, 8'h05, 8'h01, 8'hbc, 16'h0102};
    rows[6]  = '{8'h77, 8'h17, 8'h01, 8'h07, 8'h01, 8'h43, 8'h0f, 8'h01, 8'h43, 16'h0102};
    rows[7]  = '{8'h07, 8'h12, 8'h01, 8'h06, 8'h03, 8'hbc, 8'h07, 8'h03, 8'h9c, 16'h0103};
    rows[8]  = '{8'h07, 8'h12, 8'h01, 8'h06, 8'h01, 8'hbc, 8'h06, 8'h01, 8'hdc, 16'h0103};
    rows[9]  = '{8'h07, 8'h15, 8'h01, 8'h07, 8'h03, 8'hbc, 8'h07, 8'h07, 8'h9c, 16'h0103};
    rows[10] = '{8'h37, 8'h16, 8'h10, 8'h07, 8'h01, 8'hbc, 8'h07, 8'h01, 8'hbc, 16'h0113};
    rows[11] = '{8'h37, 8'h12, 8'h10, 8'h07, 8'h01, 8'hbc, 8'h07, 8'h01, 8'hbc, 16'h0103};
    rows[12] = '{8'h37, 8'h12, 8'h80, 8'h00, 8'h01, 8'hbc, 8'h00, 8'h01, 8'hbc, 16'h0083};
    rows[13] = '{8'h37, 8'h12, 8'h7f, 8'h00, 8'h01, 8'hbc, 8'h00, 8'h01, 8'hbc, 16'h0182};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS, rv);
    cmp("status after reset", 32'h0, rv);
    rd(ADDR_PC, rv);
    cmp("pc after reset", 32'h0, rv);
    foreach (rows[i]) begin
      ra = {2'b00, 4'hc, rows[i].b2[7:4], 2'b00};
      wr(ADDR_PC, 32'h0100, 4'hf, RESP_OKAY);
      wr(ra, {24'h0, rows[i].a0}, 4'h1, RESP_OKAY);
      wr(12'h004, {24'h0, rows[i].s0}, 4'h1, RESP_OKAY);
      wr(12'h354, {24'h0, rows[i].f0}, 4'h1, RESP_OKAY);
      exec({rows[i].b3, rows[i].b2, rows[i].op}, el);
      rd(ra, rv);
      cmp("dst", {24'h0, rows[i].a1}, rv);
      rd(12'h004, rv);
      cmp("src", {24'h0, rows[i].s1}, rv);
      rd(12'h354, rv);
      cmp("flags", {24'h0, rows[i].f1}, rv);
      rd(ADDR_PC, rv);
      cmp("pc", {16'h0, rows[i].pc1}, rv);
      n = ncyc(rows[i].op);
      cmp("cycles in range", 32'h1, {31'h0, el >= n - 1 && el <= n + 8});
    end
    // byte strobe off leaves the register alone
    wr(12'h304, 32'hff, 4'h2, RESP_OKAY);
    rd(12'h304, rv);
    cmp("strobe off", 32'h0, rv);
    wr(12'h40c, 32'h1, 4'hf, RESP_SLVERR);
    rd(12'h40c, rv);
    cmp("unmapped data", 32'h0, rv);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr});
    wr(ADDR_STATUS, 32'hf, 4'hf, RESP_OKAY);
    rd(ADDR_STATUS, rv);
    cmp("status kept", 32'ha, rv);
    cmp("status resp", {30'h0, RESP_OKAY}, {30'h0, rr});
    // pc and instr writes while a branch runs are refused
    wr(ADDR_PC, 32'h0100, 4'hf, RESP_OKAY);
    wr(ADDR_INSTR, 32'h00101237, 4'hf, RESP_OKAY);
    wr(ADDR_PC, 32'h0055, 4'hf, RESP_SLVERR);
    wr(ADDR_INSTR, 32'h00011257, 4'hf, RESP_SLVERR);
    wait_idle(rv);
    rd(ADDR_PC, rv);
    cmp("pc after refusals", 32'h0113, rv);
    rd(12'h304, rv);
    cmp("dst after refusals", 32'h0, rv);
    // compare with direction 1 is illegal
    wr(ADDR_INSTR, 32'h00011317, 4'hf, RESP_OKAY);
    rd(ADDR_STATUS, rv);
    cmp("illegal status", 32'h4, rv & 32'h5);
    rd(ADDR_PC, rv);
    cmp("pc after illegal", 32'h0113, rv);
    wr(ADDR_INSTR, 32'h00101237, 4'hf, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_STATUS, rv);
    cmp("status after second reset", 32'h0, rv);
    rd(ADDR_PC, rv);
    cmp("pc after second reset", 32'h0, rv);
    test_done();
  end
endmodule : tb_bit_manipulation_unit
